// *** testbench/config_prom_readout_control_tb.sv ***
// Purpose: Self-checking bench of the configuration memory readout control.
// Assumes: Short release and power-down counts; memory word is its address xor a5.
// Notes: Registers are reached through single AHB-Lite word transfers.
module config_prom_readout_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, por_ok, vcco_ok, below_pd, hsel, hwrite, ce_n, busy;
	logic monitor_low, prog_low, oe_out, oe_oe_n, cf_out, cf_oe_n, data_oe_n;
	logic clk_out, clk_oe_n, chain_n, standby;
	logic [31:0] haddr, hwdata, x;
	logic [1:0] htrans;
	logic [23:0] mem_addr;
	logic [7:0] mem_rdata, data_out;
	wire oe_wire, cf_wire, config_clk;
	int err_count, tests_run, n;
	cprc_pkg::cprc_ahb_rsp_t ahb_rsp;
	wire cprc_pkg::cprc_supply_t supply = {por_ok, vcco_ok, below_pd};
	wire cprc_pkg::cprc_ahb_req_t ahb_req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata,
		ahb_rsp.hreadyout};
	assign mem_rdata = mem_addr[7:0] ^ 8'ha5;
	cprc_top #(.PARALLEL_VARIANT(1'b1), .RELEASE_CYCLES(20), .PD_CYCLES(10)) uut (
		.clk(clk), .rst_n(rst_n), .supply(supply), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
		.oe_reset_in(oe_wire), .oe_reset_out(oe_out), .oe_reset_oe_n(oe_oe_n), .ce_n(ce_n),
		.config_pulse_n_in(cf_wire), .config_pulse_n_out(cf_out),
		.config_pulse_n_oe_n(cf_oe_n), .busy(busy), .config_clk(config_clk),
		.revision_select_pins(2'h0), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.data_out(data_out), .data_oe_n(data_oe_n), .prom_clock_out(clk_out),
		.prom_clock_oe_n(clk_oe_n), .chain_enable_out_n(chain_n), .standby(standby));
	cprc_target_model p (.config_clk(config_clk), .monitor_low(monitor_low),
		.prog_low(prog_low), .oe_reset_out(oe_out), .oe_reset_oe_n(oe_oe_n),
		.config_pulse_n_out(cf_out), .config_pulse_n_oe_n(cf_oe_n), .oe_wire(oe_wire),
		.cf_wire(cf_wire));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic final_report;
		if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// The address phase is held until hready, then hwdata until hready again.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (ahb_rsp.hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (ahb_rsp.hreadyout !== 1'b1);
		rd = ahb_rsp.hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] t;
		bus(1'b1, a, d, t);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] t;
		bus(1'b0, a, 32'h0, t);
		chk(t, exp);
	endtask
	task automatic edges(input int k);
		p.send_edges(k);
		cyc(6);
	endtask
	task automatic pulse;
		prog_low <= 1'b1;
		cyc(5);
		prog_low <= 1'b0;
		cyc(5);
	endtask
	initial begin
		#200000;
		err_count++;
		final_report;
	end
	initial begin
		{rst_n, por_ok, vcco_ok, below_pd, hsel, hwrite, busy, monitor_low, prog_low} = 9'h0;
		{haddr, hwdata, htrans} = 66'h0;
		ce_n = 1'b1;
		cyc(5);
		rst_n <= 1'b1;
		cyc(1);
		rchk(32'h0, 32'h0);
		rchk(32'h4, 32'h0);
		rchk(32'h20, 32'hffffff);
		rchk(32'h40, 32'h0);
		chk(ahb_rsp.hresp, 1'b0);
		chk(oe_oe_n, 1'b0);
		por_ok <= 1'b1;
		cyc(40);
		chk(oe_oe_n, 1'b0);
		vcco_ok <= 1'b1;
		cyc(15);
		chk(oe_oe_n, 1'b0);
		n = 0;
		while (oe_oe_n !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk(n + 15 >= 20 && n < 40, 1'b1);
		below_pd <= 1'b1;
		cyc(5);
		below_pd <= 1'b0;
		cyc(5);
		chk(oe_oe_n, 1'b1);
		below_pd <= 1'b1;
		cyc(20);
		chk(oe_oe_n, 1'b0);
		below_pd <= 1'b0;
		cyc(40);
		chk(oe_oe_n, 1'b1);
		edges(2);
		chk({standby, chain_n, data_oe_n, mem_addr}, {3'h7, 24'h0});
		ce_n <= 1'b0;
		cyc(3);
		edges(3);
		chk({mem_addr, data_out, data_oe_n, chain_n, clk_oe_n, clk_out},
			{24'h3, 8'ha7, 4'b0100});
		rchk(32'hc, 32'h3);
		wr(32'h0, 32'h2);
		busy <= 1'b1;
		cyc(3);
		edges(2);
		chk({mem_addr, data_out, data_oe_n}, {24'h3, 8'ha7, 1'b0});
		wr(32'h0, 32'h6);
		edges(2);
		chk(mem_addr, 24'h5);
		busy <= 1'b0;
		prog_low <= 1'b1;
		cyc(5);
		chk({mem_addr, data_oe_n}, {24'h0, 1'b0});
		prog_low <= 1'b0;
		cyc(5);
		edges(2);
		monitor_low <= 1'b1;
		cyc(5);
		chk({mem_addr, chain_n, data_oe_n}, {24'h0, 2'b11});
		monitor_low <= 1'b0;
		cyc(5);
		wr(32'h14, 32'h100);
		wr(32'h24, 32'h102);
		wr(32'h0, 32'h19);
		wr(32'h4, 32'h1);
		n = 0;
		while (cf_oe_n !== 1'b0 && n < 5) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (cf_oe_n === 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(n, cprc_pkg::CFG_PULSE_CYCLES);
		cyc(5);
		pulse;
		chk(mem_addr, 24'h100);
		edges(3);
		chk({mem_addr, chain_n, data_oe_n, clk_oe_n}, {24'h102, 3'b111});
		wr(32'h18, 32'hfffffe);
		wr(32'h0, 32'h29);
		pulse;
		pulse;
		chk(mem_addr, 24'hfffffe);
		edges(3);
		chk({mem_addr, chain_n, data_oe_n}, {24'hffffff, 2'b01});
		bus(1'b0, 32'h8, 32'h0, x);
		chk(x[3], 1'b1);
		final_report;
	end
endmodule

// *** testbench/cprc_target_model.sv ***
// Purpose: Model of the target's configuration port and of the board wiring around it.
// Assumes: Both shared wires carry pull-ups; the link clock rests low between frames.
// Notes: Frames of link clock edges are made by send_edges at a 125 ns period.
module cprc_target_model (
	output logic config_clk,
	input wire logic monitor_low,
	input wire logic prog_low,
	input wire logic oe_reset_out,
	input wire logic oe_reset_oe_n,
	input wire logic config_pulse_n_out,
	input wire logic config_pulse_n_oe_n,
	output logic oe_wire,
	output logic cf_wire
);
	timeunit 1ns;
	timeprecision 100ps;
	// A power monitor may hold the reset wire low on top of the device.
	assign oe_wire = ((!oe_reset_oe_n && !oe_reset_out) || monitor_low) ? 1'b0 : 1'b1;
	assign cf_wire = ((!config_pulse_n_oe_n && !config_pulse_n_out) || prog_low) ? 1'b0 : 1'b1;
	// No JTAG lines are modelled, so they rest static throughout.
	initial config_clk = 1'b0;
	task automatic send_edges(input int n);
		// Start off the system clock's edges so that no link edge meets one.
		#2;
		repeat (n) begin
			#62.5 config_clk = 1'b1;
			#62.5 config_clk = 1'b0;
		end
	endtask
endmodule

// *** verilog/cprc_pkg.sv ***
// Purpose: Shared constants and types of the configuration memory readout control.
// Assumes: 100 MHz system clock; 32-bit AHB-Lite register bus.
// Notes: Times are kept in ns and converted to clock counts here.
package cprc_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int REV_N = 4;
	localparam int CLK_PERIOD_NS = 10;
	// Minimum release delay after the supplies pass their thresholds.
	localparam int RESET_RELEASE_DELAY_MIN_NS = 500000;
	localparam int RESET_RELEASE_DELAY_MAX_NS = 30000000;
	localparam int RESET_RELEASE_CYCLES =
		(RESET_RELEASE_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Minimum time below the power-down threshold before a reset.
	localparam int POWER_DOWN_MIN_NS = 10000000;
	localparam int POWER_DOWN_CYCLES = (POWER_DOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CFG_PULSE_MIN_NS = 300;
	localparam int CFG_PULSE_MAX_NS = 500;
	localparam int CFG_PULSE_CYCLES = (CFG_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] ADDR_OFS = 8'h0c;
	localparam logic [7:0] BANK_START_OFS = 8'h10;
	localparam logic [7:0] BANK_END_OFS = 8'h20;
	// Control register fields.
	localparam int CTRL_REV_EN_BIT = 0;
	localparam int CTRL_PAR_MODE_BIT = 1;
	localparam int CTRL_DECOMP_BIT = 2;
	localparam int CTRL_INT_SEL_BIT = 3;
	localparam int CTRL_REV_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CMD_RECONFIG_BIT = 0;
	localparam logic [ADDR_W-1:0] BANK_START_RESET = 24'h000000;
	localparam logic [ADDR_W-1:0] BANK_END_RESET = 24'hffffff;

	typedef enum logic [1:0] {CPRC_PWR_OFF, CPRC_PWR_WAIT, CPRC_PWR_ON} cprc_pwr_t;

	typedef struct packed {
		logic vccint_por_ok;
		logic vcco_ok;
		logic below_power_down_threshold;
	} cprc_supply_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} cprc_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} cprc_ahb_rsp_t;

	typedef struct packed {
		cprc_pwr_t pwr;
		logic [23:0] delay_cnt;
		logic [23:0] pd_cnt;
		logic [1:0] por_s;
		logic [1:0] vcco_s;
		logic [1:0] pd_s;
		logic [1:0] oe_s;
		logic [1:0] ce_s;
		logic [1:0] busy_s;
		logic [2:0] cf_s;
		logic [2:0] cclk_s;
		logic [1:0] rsel_s1;
		logic [1:0] rsel_s2;
		logic [1:0] rev;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic data_drv;
		logic clk_drv;
		logic clk_out;
		logic ceo_n;
		logic pulse_on;
		logic [5:0] pulse_cnt;
		logic [7:0] ctrl;
		logic [REV_N-1:0][ADDR_W-1:0] bank_start;
		logic [REV_N-1:0][ADDR_W-1:0] bank_end;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
	} cprc_state_t;
endpackage

// *** verilog/cprc_top.sv ***
// Purpose: Readout control of a configuration memory feeding a logic target.
// Assumes: Pins are asynchronous and pass two flip-flops; memory read data is combinational.
// Notes: Registers sit on AHB-Lite, zero wait states, always OKAY.
// Operation
// [R1] Hold reset pin low while supplies ramp.
// [R2] Delay pin release after supplies pass thresholds.
// [R3] Core supply loss resets and holds pin low.
// [R4] Reset pin polarity is fixed active low.
// [R5] Serial variant checks only the core supply.
// [R6] Parallel variant also waits for output supply.
// [R7] External monitor may hold reset pin low.
// [R8] Reset pin low or enable high resets.
// [R9] Enable high means standby, outputs off.
// [R10] JTAG pins stay static during standby.
// [R11] Count up; at terminal count stop, chain low.
// [R12] Stop at revision end address, chain high.
// [R13] Flow-control high holds address and outputs.
// [R14] Flow control only in parallel uncompressed mode.
// [R15] Config pulse low resets address, outputs active.
// [R16] Board ties enable low without standby.
// [R17] Sample revision on config pulse rising edge.
// [R18] Reconfigure command pulses config pulse low.
// [R19] Release delay at least half a millisecond.
// [R20] Reset only after long enough supply loss.
// [R21] Advance one word per configuration clock edge.
module cprc_top #(
	parameter bit PARALLEL_VARIANT = 1'b1,
	parameter int RELEASE_CYCLES = cprc_pkg::RESET_RELEASE_CYCLES,
	parameter int PD_CYCLES = cprc_pkg::POWER_DOWN_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire cprc_pkg::cprc_supply_t supply,
	input wire cprc_pkg::cprc_ahb_req_t ahb_req,
	output cprc_pkg::cprc_ahb_rsp_t ahb_rsp,
	input wire logic oe_reset_in,
	output logic oe_reset_out,
	output logic oe_reset_oe_n,
	input wire logic ce_n,
	input wire logic config_pulse_n_in,
	output logic config_pulse_n_out,
	output logic config_pulse_n_oe_n,
	input wire logic busy,
	input wire logic config_clk,
	input wire logic [1:0] revision_select_pins,
	output logic [cprc_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [cprc_pkg::DATA_W-1:0] mem_rdata,
	output logic [cprc_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n,
	output logic prom_clock_out,
	output logic prom_clock_oe_n,
	output logic chain_enable_out_n,
	output logic standby
);
	cprc_pkg::cprc_state_t r_reg;
	cprc_pkg::cprc_state_t r_next;
	logic enabled;
	logic cf_low;
	logic cf_rise;
	logic cclk_rise;
	logic rev_en;
	logic busy_hold;
	logic terminal_count;
	logic rev_end;
	logic ready;
	logic [cprc_pkg::ADDR_W-1:0] start_addr;
	logic [cprc_pkg::ADDR_W-1:0] revision_end_address;

	// Pin release needs only the core supply in the serial variant.
	assign ready = r_reg.por_s[1] && (!PARALLEL_VARIANT || r_reg.vcco_s[1]); // [R5] [R6]
	assign enabled = r_reg.pwr == cprc_pkg::CPRC_PWR_ON && r_reg.oe_s[1] && !r_reg.ce_s[1];
	assign cf_low = !r_reg.cf_s[1];
	assign cf_rise = r_reg.cf_s[1] && !r_reg.cf_s[2];
	assign cclk_rise = r_reg.cclk_s[1] && !r_reg.cclk_s[2];
	assign rev_en = PARALLEL_VARIANT && r_reg.ctrl[cprc_pkg::CTRL_REV_EN_BIT];
	assign busy_hold = PARALLEL_VARIANT && r_reg.ctrl[cprc_pkg::CTRL_PAR_MODE_BIT] &&
		!r_reg.ctrl[cprc_pkg::CTRL_DECOMP_BIT] && r_reg.busy_s[1]; // [R14]
	assign start_addr = rev_en ? r_reg.bank_start[r_reg.rev] : '0;
	assign revision_end_address = r_reg.bank_end[r_reg.rev];
	assign terminal_count = &r_reg.addr;
	assign rev_end = rev_en && r_reg.addr == revision_end_address;

	always_comb begin
		logic [7:0] ra;
		ra = ahb_req.haddr[7:0];
		r_next = r_reg;
		r_next.por_s = {r_reg.por_s[0], supply.vccint_por_ok};
		r_next.vcco_s = {r_reg.vcco_s[0], supply.vcco_ok};
		r_next.pd_s = {r_reg.pd_s[0], supply.below_power_down_threshold};
		r_next.oe_s = {r_reg.oe_s[0], oe_reset_in};
		r_next.ce_s = {r_reg.ce_s[0], ce_n};
		r_next.busy_s = {r_reg.busy_s[0], busy};
		r_next.cf_s = {r_reg.cf_s[1:0], config_pulse_n_in};
		r_next.cclk_s = {r_reg.cclk_s[1:0], config_clk};
		r_next.rsel_s1 = revision_select_pins;
		r_next.rsel_s2 = r_reg.rsel_s1;
		r_next.clk_out = r_reg.cclk_s[1];

		unique case (r_reg.pwr)
			cprc_pkg::CPRC_PWR_OFF: begin
				r_next.delay_cnt = '0;
				if (ready) begin
					r_next.pwr = cprc_pkg::CPRC_PWR_WAIT;
				end
			end
			cprc_pkg::CPRC_PWR_WAIT: begin
				if (!ready) begin
					r_next.pwr = cprc_pkg::CPRC_PWR_OFF;
				end else if (r_reg.delay_cnt == 24'(RELEASE_CYCLES - 1)) begin
					r_next.pwr = cprc_pkg::CPRC_PWR_ON; // [R2] [R19]
				end else begin
					r_next.delay_cnt = r_reg.delay_cnt + 24'h000001;
				end
			end
			cprc_pkg::CPRC_PWR_ON: begin
			end
		endcase
		// A brief dip is ignored; only a long one resets the device.
		if (r_reg.pd_s[1]) begin
			if (r_reg.pd_cnt == 24'(PD_CYCLES - 1)) begin
				r_next.pd_cnt = '0;
				r_next.pwr = cprc_pkg::CPRC_PWR_OFF; // [R3] [R20]
			end else begin
				r_next.pd_cnt = r_reg.pd_cnt + 24'h000001;
			end
		end else begin
			r_next.pd_cnt = '0;
		end

		if (cf_rise) begin
			r_next.rev = r_reg.ctrl[cprc_pkg::CTRL_INT_SEL_BIT] ?
				r_reg.ctrl[cprc_pkg::CTRL_REV_LSB +: 2] : r_reg.rsel_s2; // [R17]
		end

		if (!enabled) begin
			r_next.addr = start_addr; // [R8] [R9]
			r_next.ceo_n = 1'b1;
			r_next.data_drv = 1'b0;
			r_next.clk_drv = 1'b0;
		end else if (cf_low) begin
			r_next.addr = start_addr; // [R15]
			r_next.ceo_n = 1'b1;
			r_next.data_drv = 1'b1;
			r_next.clk_drv = 1'b1;
		end else if (busy_hold) begin
			r_next.ceo_n = 1'b1; // [R13]
			r_next.data_drv = 1'b1;
			r_next.clk_drv = 1'b1;
		end else if (terminal_count) begin
			r_next.ceo_n = 1'b0; // [R11]
			r_next.data_drv = 1'b0;
			r_next.clk_drv = 1'b0;
		end else if (rev_end) begin
			r_next.ceo_n = 1'b1; // [R12]
			r_next.data_drv = 1'b0;
			r_next.clk_drv = 1'b0;
		end else begin
			r_next.ceo_n = 1'b1;
			r_next.data_drv = 1'b1;
			r_next.clk_drv = 1'b1;
			if (cclk_rise) begin
				r_next.data = mem_rdata; // [R21]
				r_next.addr = r_reg.addr + 24'h000001; // [R11]
			end
		end

		if (r_reg.pulse_on) begin
			if (r_reg.pulse_cnt == 6'(cprc_pkg::CFG_PULSE_CYCLES - 1)) begin
				r_next.pulse_on = 1'b0;
			end else begin
				r_next.pulse_cnt = r_reg.pulse_cnt + 6'h01;
			end
		end

		// Write data phase of the previous address phase.
		r_next.wr_pend = 1'b0;
		if (r_reg.wr_pend) begin
			if (r_reg.wr_addr == cprc_pkg::CTRL_OFS) begin
				r_next.ctrl = ahb_req.hwdata[7:0];
			end else if (r_reg.wr_addr == cprc_pkg::CMD_OFS) begin
				if (ahb_req.hwdata[cprc_pkg::CMD_RECONFIG_BIT] && !r_reg.pulse_on) begin
					r_next.pulse_on = 1'b1; // [R18]
					r_next.pulse_cnt = '0;
				end
			end
			for (int i = 0; i < cprc_pkg::REV_N; i++) begin
				if (r_reg.wr_addr == 8'(cprc_pkg::BANK_START_OFS + 4 * i)) begin
					r_next.bank_start[i] = ahb_req.hwdata[cprc_pkg::ADDR_W-1:0];
				end
				if (r_reg.wr_addr == 8'(cprc_pkg::BANK_END_OFS + 4 * i)) begin
					r_next.bank_end[i] = ahb_req.hwdata[cprc_pkg::ADDR_W-1:0];
				end
			end
		end
		if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
			r_next.hrdata = '0;
			if (ahb_req.hwrite) begin
				r_next.wr_pend = 1'b1;
				r_next.wr_addr = ra;
			end else if (ra == cprc_pkg::CTRL_OFS) begin
				r_next.hrdata = {24'h000000, r_reg.ctrl};
			end else if (ra == cprc_pkg::STATUS_OFS) begin
				r_next.hrdata = {21'h00000, r_reg.pwr, r_reg.rev, r_reg.pulse_on, busy_hold,
					rev_end, terminal_count, r_reg.ce_s[1], enabled,
					r_reg.pwr == cprc_pkg::CPRC_PWR_ON};
			end else if (ra == cprc_pkg::ADDR_OFS) begin
				r_next.hrdata = {8'h00, r_reg.addr};
			end else begin
				for (int i = 0; i < cprc_pkg::REV_N; i++) begin
					if (ra == 8'(cprc_pkg::BANK_START_OFS + 4 * i)) begin
						r_next.hrdata = {8'h00, r_reg.bank_start[i]};
					end
					if (ra == 8'(cprc_pkg::BANK_END_OFS + 4 * i)) begin
						r_next.hrdata = {8'h00, r_reg.bank_end[i]};
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.pwr <= cprc_pkg::CPRC_PWR_OFF;
			r_reg.ceo_n <= 1'b1;
			r_reg.cf_s <= 3'h7;
			r_reg.oe_s <= 2'h0;
			r_reg.ce_s <= 2'h3;
			r_reg.ctrl <= cprc_pkg::CTRL_RESET;
			r_reg.bank_start <= {cprc_pkg::REV_N{cprc_pkg::BANK_START_RESET}};
			r_reg.bank_end <= {cprc_pkg::REV_N{cprc_pkg::BANK_END_RESET}};
		end else begin
			r_reg <= r_next;
		end
	end

	// The reset pin is open drain, low only; no polarity option exists.
	assign oe_reset_out = 1'b0; // [R4]
	assign oe_reset_oe_n = r_reg.pwr == cprc_pkg::CPRC_PWR_ON; // [R1] [R3]
	assign config_pulse_n_out = 1'b0;
	assign config_pulse_n_oe_n = !r_reg.pulse_on;
	assign mem_addr = r_reg.addr;
	assign data_out = r_reg.data;
	assign data_oe_n = !r_reg.data_drv;
	assign prom_clock_out = r_reg.clk_out;
	assign prom_clock_oe_n = !r_reg.clk_drv;
	assign chain_enable_out_n = r_reg.ceo_n;
	assign standby = r_reg.ce_s[1];
	assign ahb_rsp.hrdata = r_reg.hrdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_hold_low;
		!r_reg.por_s[1] && r_reg.pwr != cprc_pkg::CPRC_PWR_ON
			|=> !oe_reset_oe_n && !oe_reset_out;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("reset pin not held low"); // [R1]

	property p_release_delay;
		$rose(oe_reset_oe_n) |-> $past(r_reg.delay_cnt) == 24'(RELEASE_CYCLES - 1);
	endproperty
	a_release_delay: assert property (p_release_delay) else $error("release too early"); // [R2]

	property p_power_down;
		r_reg.pd_s[1] && r_reg.pd_cnt == 24'(PD_CYCLES - 1) |=> !oe_reset_oe_n [*2];
	endproperty
	a_power_down: assert property (p_power_down) else $error("no power-down reset"); // [R3]

	property p_variant_wait;
		r_reg.pwr == cprc_pkg::CPRC_PWR_OFF && PARALLEL_VARIANT && !r_reg.vcco_s[1]
			|=> r_reg.pwr == cprc_pkg::CPRC_PWR_OFF;
	endproperty
	a_variant_wait: assert property (p_variant_wait) else $error("released without vcco"); // [R6]

	property p_standby;
		r_reg.ce_s[1] |=> chain_enable_out_n && data_oe_n && prom_clock_oe_n
			&& r_reg.addr == $past(start_addr);
	endproperty
	a_standby: assert property (p_standby) else $error("standby outputs wrong"); // [R9]

	property p_terminal;
		enabled && !cf_low && !busy_hold && terminal_count
			|=> !chain_enable_out_n && data_oe_n && prom_clock_oe_n && $stable(r_reg.addr);
	endproperty
	a_terminal: assert property (p_terminal) else $error("terminal count stop wrong"); // [R11]

	property p_rev_stop;
		enabled && !cf_low && !busy_hold && !terminal_count && rev_end
			|=> chain_enable_out_n && prom_clock_oe_n && data_oe_n && $stable(r_reg.addr);
	endproperty
	a_rev_stop: assert property (p_rev_stop) else $error("revision end stop wrong"); // [R12]

	property p_busy;
		enabled && !cf_low && busy_hold |=> $stable(r_reg.addr) && !data_oe_n && $stable(data_out);
	endproperty
	a_busy: assert property (p_busy) else $error("flow-control hold wrong"); // [R13]

	property p_cf_reset;
		enabled && cf_low |=> r_reg.addr == $past(start_addr) && !data_oe_n;
	endproperty
	a_cf_reset: assert property (p_cf_reset) else $error("config pulse reset wrong"); // [R15]

	property p_rev_sample;
		cf_rise && r_reg.ctrl[cprc_pkg::CTRL_INT_SEL_BIT]
			|=> r_reg.rev == $past(r_reg.ctrl[cprc_pkg::CTRL_REV_LSB +: 2]);
	endproperty
	a_rev_sample: assert property (p_rev_sample) else $error("revision not sampled"); // [R17]

	property p_cfg_pulse;
		$fell(r_reg.pulse_on) |-> $past(r_reg.pulse_cnt) == 6'(cprc_pkg::CFG_PULSE_CYCLES - 1);
	endproperty
	a_cfg_pulse: assert property (p_cfg_pulse) else $error("config pulse length wrong"); // [R18]

	property p_advance;
		enabled && !cf_low && !busy_hold && !terminal_count && !rev_end && cclk_rise
			|=> r_reg.addr == $past(r_reg.addr) + 24'h000001 && data_out == $past(mem_rdata);
	endproperty
	a_advance: assert property (p_advance) else $error("address did not advance"); // [R21]

	property p_supply_release;
		r_reg.pwr == cprc_pkg::CPRC_PWR_OFF && r_reg.por_s[1] && !r_reg.pd_s[1]
			&& (!PARALLEL_VARIANT || r_reg.vcco_s[1])
			|=> r_reg.pwr == cprc_pkg::CPRC_PWR_WAIT;
	endproperty
	a_supply_release: assert property (p_supply_release) else $error("supply release missed"); // [R5]

	property p_pin_reset;
		r_reg.pwr == cprc_pkg::CPRC_PWR_ON && !r_reg.oe_s[1]
			|=> chain_enable_out_n && data_oe_n && prom_clock_oe_n
			&& r_reg.addr == $past(start_addr);
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset outputs wrong"); // [R8]

	property p_busy_ignored;
		enabled && !cf_low && r_reg.busy_s[1] && r_reg.ctrl[cprc_pkg::CTRL_DECOMP_BIT]
			&& !terminal_count && !rev_end && cclk_rise
			|=> r_reg.addr == $past(r_reg.addr) + 24'h000001;
	endproperty
	a_busy_ignored: assert property (p_busy_ignored) else $error("flow control not ignored"); // [R14]

	property p_dip_filter;
		r_reg.pwr == cprc_pkg::CPRC_PWR_ON && r_reg.pd_s[1]
			&& r_reg.pd_cnt != 24'(PD_CYCLES - 1)
			|=> r_reg.pwr == cprc_pkg::CPRC_PWR_ON;
	endproperty
	a_dip_filter: assert property (p_dip_filter) else $error("short dip caused reset"); // [R20]
endmodule
